// ---- src/tcc_pkg.sv ----
// constants, field layouts and types for the torque table and commutation stage
package tcc_pkg;

    // ==========================================================
    // register offsets on the plain register port
    localparam logic [7:0] REG_CTRL   = 8'h00; // commutation_enable in bit 0
    localparam logic [7:0] REG_PAIR   = 8'h04; // phase_output_pair_address
    localparam logic [7:0] REG_DENOM  = 8'h08; // cycle_denominator
    localparam logic [7:0] REG_NUMER  = 8'h0c; // cycle_count_numerator
    localparam logic [7:0] REG_ANGLE  = 8'h10; // inter_phase_angle
    localparam logic [7:0] REG_FBPTR  = 8'h14; // commutation_feedback_pointer
    localparam logic [7:0] REG_PHREF  = 8'h18; // phase reference offset
    localparam logic [7:0] REG_TDEF   = 8'h1c; // torque_table_define_command
    localparam logic [7:0] REG_TDATA  = 8'h20; // next table constant
    localparam logic [7:0] REG_STATUS = 8'h24; // table and phase state
    localparam logic [7:0] REG_OUT    = 8'h28; // last phase commands

    // ==========================================================
    // field positions
    localparam int TDEF_SPAN_LSB  = 0;  // span in motor counts, 24 bits
    localparam int TDEF_ENT_LSB   = 24; // entry count, 7 bits
    localparam int ST_READY_BIT   = 0;
    localparam int ST_LOADING_BIT = 1;
    localparam int ST_DEFERR_BIT  = 2;
    localparam int ST_LEFT_LSB    = 8;
    localparam int ST_PHASE_LSB   = 16;

    // ==========================================================
    // converter pair and feedback address spaces
    localparam logic [15:0] PAIR_FIRST = 16'hc002;
    localparam logic [15:0] PAIR_LAST  = 16'hc03a;
    localparam logic [15:0] PAIR_MASK  = 16'h0007; // pairs are eight apart
    localparam int          PAIR_SHIFT = 3;
    localparam logic [15:0] FB_FIRST   = 16'hc001;
    localparam logic [15:0] FB_LAST    = 16'hc01d;
    localparam logic [15:0] FB_MASK    = 16'h0003; // encoders are four apart
    localparam int          FB_SHIFT   = 2;
    localparam int          NUM_ENC    = 8;

    // ==========================================================
    // reset values
    localparam logic [7:0]  RST_DENOM = 8'h01;
    localparam logic [15:0] RST_NUMER = 16'h03e8;
    localparam logic [7:0]  RST_ANGLE = 8'h55; // three-phase, 85 of 256

    // ==========================================================
    // table geometry and converter range
    localparam int                 TBL_DEPTH = 64;
    localparam int                 IDX_W     = 6;
    localparam int                 ENT_W     = 7;
    localparam logic [ENT_W-1:0]   ENT_MAX   = 7'h40;
    localparam logic signed [18:0] DAC_MAX   = 19'sh07fff;
    localparam logic signed [18:0] DAC_MIN   = -19'sh08000;
    localparam int                 SIN_SHIFT = 15;

    // quarter sine, 17 points, full scale 32767
    localparam logic [15:0] SIN_Q [0:16] = '{
        16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56,
        16'h471c, 16'h5133, 16'h5a82, 16'h62f1, 16'h6a6d, 16'h70e2,
        16'h7641, 16'h7a7c, 16'h7d89, 16'h7f61, 16'h7fff};

    // ==========================================================
    // types
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wrData;
        logic        wr;
        logic        rd;
    } tcc_reg_req_t;

    typedef logic [NUM_ENC-1:0][23:0] tcc_enc_bank_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WRAP,
        ST_SEG,
        ST_INTERP,
        ST_SUM,
        ST_COMM,
        ST_OUT
    } tcc_state_t;

endpackage : tcc_pkg

// ---- src/tcc_motor_out.sv ----
// per-motor torque table correction and two-phase commutation output
`timescale 1ns/1ns

// Overview of operation
// - one table per motor, own position only
// - spacing is span divided by entries
// - entry k at k spacings; zero at zero
// - positions wrapped into zero to span
// - next constants after define fill table
// - entries signed sixteen-bit converter units
// - linear interpolation between adjacent entries
// - commutate only when enable equals one
// - phase from incremental counter input
// - pointer selects encoder phase register
// - two analog channels carry phase commands
// - pair address limited to eight values
// - counts per cycle is numerator over denominator
// - angle in 256ths of a cycle
// - alternate angle reverses the phasing
// - phase referenced by software offset
// - positive command counts encoder upward
module tcc_motor_out (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire tcc_pkg::tcc_reg_req_t       regReq,
    output logic [31:0]                      regRdData,
    input  wire logic                        servoTick,
    input  wire logic signed [15:0]          servoOut,
    input  wire logic signed [23:0]          motorPos,
    input  wire tcc_pkg::tcc_enc_bank_t      encPhase,
    output logic signed [15:0]               dacA,
    output logic signed [15:0]               dacB,
    output logic [2:0]                       dacPair,
    output logic                             dacStrobe,
    output logic                             commActive
);

    // ==========================================================
    // settings
    logic                          commEnable;
    logic [15:0]                   pairAddr;
    logic [7:0]                    cycleDenom;
    logic [15:0]                   cycleNumer;
    logic [7:0]                    phaseAngle;
    logic [15:0]                   fbPointer;
    logic [7:0]                    phaseRef;

    // table state
    logic signed [15:0]            corrTable [0:tcc_pkg::TBL_DEPTH-1];
    logic [tcc_pkg::ENT_W-1:0]     tblEntries;
    logic [23:0]                   tblSpan;
    logic [tcc_pkg::ENT_W-1:0]     loadIdx;
    logic [tcc_pkg::ENT_W-1:0]     loadLeft;
    logic                          tblReady;
    logic                          defErr;

    // pipeline state
    tcc_pkg::tcc_state_t           state;
    logic signed [15:0]            servoHeld;
    logic signed [23:0]            posHeld;
    logic signed [23:0]            encHeld;
    logic [23:0]                   wPos;
    logic [15:0]                   cMod;
    logic [tcc_pkg::IDX_W-1:0]     seg;
    logic [23:0]                   frac;
    logic [7:0]                    phase;
    logic signed [17:0]            corr;
    logic signed [15:0]            cmd;
    logic signed [15:0]            phA;
    logic signed [15:0]            phB;

    // ==========================================================
    // quarter-wave sine lookup, 64 points per cycle
    function automatic logic signed [16:0] sineOf(input logic [7:0] theta);
        logic [3:0]  k;
        logic [15:0] mag;
        k = theta[5:2];
        mag = theta[6] ? tcc_pkg::SIN_Q[5'd16 - {1'b0, k}] : tcc_pkg::SIN_Q[k];
        sineOf = theta[7] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction : sineOf

    // ==========================================================
    // address checks and combinational arithmetic
    logic                          pairLegal;
    logic                          fbLegal;
    logic [15:0]                   pairOff;
    logic [15:0]                   fbOff;
    logic [2:0]                    fbIdx;
    logic                          tblOn;
    logic signed [24:0]            posX;
    logic signed [24:0]            spanX;
    logic signed [24:0]            wrapRem;
    logic signed [32:0]            cProd;
    logic signed [32:0]            cRem;
    logic [30:0]                   segProd;
    logic [30:0]                   segQuot;
    logic [31:0]                   phScaled;
    logic signed [15:0]            e0;
    logic signed [15:0]            e1;
    logic signed [16:0]            eDiff;
    logic signed [41:0]            iProd;
    logic signed [41:0]            iQuot;
    logic signed [18:0]            sum;
    logic [7:0]                    thetaA;
    logic [7:0]                    thetaB;
    logic signed [32:0]            pA;
    logic signed [32:0]            pB;

    assign pairOff = regReq.wrData[15:0] - tcc_pkg::PAIR_FIRST;
    assign fbOff   = regReq.wrData[15:0] - tcc_pkg::FB_FIRST;
    // only the eight documented pair addresses are accepted
    assign pairLegal = regReq.wrData[15:0] >= tcc_pkg::PAIR_FIRST
                    && regReq.wrData[15:0] <= tcc_pkg::PAIR_LAST
                    && (pairOff & tcc_pkg::PAIR_MASK) == 16'h0000;
    assign fbLegal = regReq.wrData[15:0] >= tcc_pkg::FB_FIRST
                  && regReq.wrData[15:0] <= tcc_pkg::FB_LAST
                  && (fbOff & tcc_pkg::FB_MASK) == 16'h0000;
    // feedback register index from the pointer
    assign fbIdx = 3'((fbPointer - tcc_pkg::FB_FIRST) >> tcc_pkg::FB_SHIFT);

    assign tblOn   = tblReady && tblSpan != 24'h000000 && tblEntries != '0;
    // wrap own motor position into 0..span
    assign posX    = {posHeld[23], posHeld};
    assign spanX   = {1'b0, tblSpan};
    assign wrapRem = (spanX == 25'sh0) ? 25'sh0 : posX % spanX;
    // position within one electrical cycle, scaled by the denominator
    assign cProd   = 33'(encHeld * $signed({1'b0, cycleDenom}));
    assign cRem    = (cycleNumer == 16'h0000) ? 33'sh0
                   : cProd % $signed({17'h00000, cycleNumer});
    // segment index and remainder: wPos * entries / span
    assign segProd  = 31'(wPos * tblEntries);
    assign segQuot  = (tblSpan == 24'h000000) ? 31'h0 : segProd / {7'h00, tblSpan};
    assign phScaled = (cycleNumer == 16'h0000) ? 32'h0
                    : ({8'h00, cMod, 8'h00}) / {16'h0000, cycleNumer};
    // entry k sits at k spacings; point zero is zero
    assign e0    = (seg == '0) ? 16'sh0000 : corrTable[seg - 1'b1];
    assign e1    = corrTable[seg];
    assign eDiff = 17'(e1) - 17'(e0);
    assign iProd = 42'(eDiff * $signed({1'b0, frac}));
    assign iQuot = (tblSpan == 24'h000000) ? 42'sh0 : iProd / $signed({18'h0, tblSpan});
    assign sum   = 19'(servoHeld) + 19'(corr);
    // second phase leads the first by the inter-phase angle
    assign thetaA = phase + phaseRef;
    assign thetaB = phase + phaseRef + phaseAngle;
    assign pA    = 33'(cmd * sineOf(thetaA));
    assign pB    = 33'(cmd * sineOf(thetaB));

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            commEnable <= 1'b0;
            pairAddr   <= tcc_pkg::PAIR_FIRST;
            cycleDenom <= tcc_pkg::RST_DENOM;
            cycleNumer <= tcc_pkg::RST_NUMER;
            phaseAngle <= tcc_pkg::RST_ANGLE;
            fbPointer  <= tcc_pkg::FB_FIRST;
            phaseRef   <= 8'h00;
        end else if (regReq.wr) begin
            if (regReq.addr == tcc_pkg::REG_CTRL) begin
                commEnable <= regReq.wrData[0];
            end else if (regReq.addr == tcc_pkg::REG_PAIR) begin
                if (pairLegal) begin
                    pairAddr <= regReq.wrData[15:0];
                end
            end else if (regReq.addr == tcc_pkg::REG_DENOM) begin
                cycleDenom <= regReq.wrData[7:0];
            end else if (regReq.addr == tcc_pkg::REG_NUMER) begin
                cycleNumer <= regReq.wrData[15:0];
            end else if (regReq.addr == tcc_pkg::REG_ANGLE) begin
                phaseAngle <= regReq.wrData[7:0];
            end else if (regReq.addr == tcc_pkg::REG_FBPTR) begin
                if (fbLegal) begin
                    fbPointer <= regReq.wrData[15:0];
                end
            end else if (regReq.addr == tcc_pkg::REG_PHREF) begin
                phaseRef <= regReq.wrData[7:0];
            end
        end
    end

    // ==========================================================
    // table definition and sequential loading
    always_ff @(posedge clk) begin
        if (rst) begin
            tblEntries <= '0;
            tblSpan    <= 24'h000000;
            loadIdx    <= '0;
            loadLeft   <= '0;
            tblReady   <= 1'b0;
            defErr     <= 1'b0;
        end else if (regReq.wr && regReq.addr == tcc_pkg::REG_TDEF) begin
            tblReady <= 1'b0;
            loadIdx  <= '0;
            if (regReq.wrData[tcc_pkg::TDEF_ENT_LSB +: tcc_pkg::ENT_W] > tcc_pkg::ENT_MAX) begin
                defErr     <= 1'b1;
                tblEntries <= '0;
                loadLeft   <= '0;
            end else begin
                defErr     <= 1'b0;
                tblEntries <= regReq.wrData[tcc_pkg::TDEF_ENT_LSB +: tcc_pkg::ENT_W];
                tblSpan    <= regReq.wrData[tcc_pkg::TDEF_SPAN_LSB +: 24];
                loadLeft   <= regReq.wrData[tcc_pkg::TDEF_ENT_LSB +: tcc_pkg::ENT_W];
            end
        end else if (regReq.wr && regReq.addr == tcc_pkg::REG_TDATA && loadLeft != '0) begin
            loadIdx  <= loadIdx + 1'b1;
            loadLeft <= loadLeft - 1'b1;
            if (loadLeft == 7'h01) begin
                tblReady <= 1'b1;
            end
        end
    end

    // table storage, written only by the load sequence
    always_ff @(posedge clk) begin
        if (regReq.wr && regReq.addr == tcc_pkg::REG_TDATA && loadLeft != '0) begin
            corrTable[loadIdx[tcc_pkg::IDX_W-1:0]] <= regReq.wrData[15:0];
        end
    end

    // ==========================================================
    // servo-cycle pipeline: wrap, index, interpolate, sum, commutate
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= tcc_pkg::ST_IDLE;
            servoHeld <= 16'sh0000;
            posHeld   <= 24'sh000000;
            encHeld   <= 24'sh000000;
            wPos      <= 24'h000000;
            cMod      <= 16'h0000;
            seg       <= '0;
            frac      <= 24'h000000;
            phase     <= 8'h00;
            corr      <= 18'sh00000;
            cmd       <= 16'sh0000;
            phA       <= 16'sh0000;
            phB       <= 16'sh0000;
        end else begin
            case (state)
                tcc_pkg::ST_IDLE: begin
                    if (servoTick) begin
                        servoHeld <= servoOut;
                        posHeld   <= motorPos;
                        encHeld   <= $signed(encPhase[fbIdx]);
                        state     <= tcc_pkg::ST_WRAP;
                    end
                end
                tcc_pkg::ST_WRAP: begin
                    wPos  <= (wrapRem < 0) ? 24'(wrapRem + spanX) : 24'(wrapRem);
                    cMod  <= (cRem < 0) ? 16'(cRem + 33'(cycleNumer)) : 16'(cRem);
                    state <= tcc_pkg::ST_SEG;
                end
                tcc_pkg::ST_SEG: begin
                    seg   <= segQuot[tcc_pkg::IDX_W-1:0];
                    frac  <= 24'(segProd - 31'(segQuot * tblSpan));
                    phase <= phScaled[7:0];
                    state <= tcc_pkg::ST_INTERP;
                end
                tcc_pkg::ST_INTERP: begin
                    corr  <= tblOn ? 18'(e0) + 18'(iQuot) : 18'sh00000;
                    state <= tcc_pkg::ST_SUM;
                end
                tcc_pkg::ST_SUM: begin
                    if (sum > tcc_pkg::DAC_MAX) begin
                        cmd <= 16'(tcc_pkg::DAC_MAX);
                    end else if (sum < tcc_pkg::DAC_MIN) begin
                        cmd <= 16'(tcc_pkg::DAC_MIN);
                    end else begin
                        cmd <= 16'(sum);
                    end
                    state <= tcc_pkg::ST_COMM;
                end
                tcc_pkg::ST_COMM: begin
                    if (commEnable) begin
                        // positive command advances the field with the counter
                        phA <= 16'(pA >>> tcc_pkg::SIN_SHIFT);
                        phB <= 16'(pB >>> tcc_pkg::SIN_SHIFT);
                    end else begin
                        phA <= cmd;
                        phB <= 16'sh0000;
                    end
                    state <= tcc_pkg::ST_OUT;
                end
                tcc_pkg::ST_OUT: begin
                    state <= tcc_pkg::ST_IDLE;
                end
                default: begin
                    state <= tcc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // converter outputs, updated once per servo cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            dacA       <= 16'sh0000;
            dacB       <= 16'sh0000;
            dacPair    <= 3'h0;
            dacStrobe  <= 1'b0;
            commActive <= 1'b0;
        end else begin
            dacStrobe <= 1'b0;
            if (state == tcc_pkg::ST_OUT) begin
                dacA       <= phA;
                dacB       <= phB;
                dacPair    <= 3'((pairAddr - tcc_pkg::PAIR_FIRST) >> tcc_pkg::PAIR_SHIFT);
                dacStrobe  <= 1'b1;
                commActive <= commEnable;
            end
        end
    end

    // ==========================================================
    // read port, data in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 32'h00000000;
        end else if (regReq.rd) begin
            if (regReq.addr == tcc_pkg::REG_CTRL) begin
                regRdData <= {31'h0, commEnable};
            end else if (regReq.addr == tcc_pkg::REG_PAIR) begin
                regRdData <= {16'h0000, pairAddr};
            end else if (regReq.addr == tcc_pkg::REG_DENOM) begin
                regRdData <= {24'h000000, cycleDenom};
            end else if (regReq.addr == tcc_pkg::REG_NUMER) begin
                regRdData <= {16'h0000, cycleNumer};
            end else if (regReq.addr == tcc_pkg::REG_ANGLE) begin
                regRdData <= {24'h000000, phaseAngle};
            end else if (regReq.addr == tcc_pkg::REG_FBPTR) begin
                regRdData <= {16'h0000, fbPointer};
            end else if (regReq.addr == tcc_pkg::REG_PHREF) begin
                regRdData <= {24'h000000, phaseRef};
            end else if (regReq.addr == tcc_pkg::REG_TDEF) begin
                regRdData <= {1'b0, tblEntries, tblSpan};
            end else if (regReq.addr == tcc_pkg::REG_STATUS) begin
                regRdData <= 32'({phase, 1'b0, loadLeft, 5'h00, defErr,
                                  (loadLeft != '0), tblReady});
            end else if (regReq.addr == tcc_pkg::REG_OUT) begin
                regRdData <= {dacB, dacA};
            end else begin
                regRdData <= 32'h00000000; // unmapped reads zero
            end
        end else begin
            regRdData <= 32'h00000000;
        end
    end

endmodule : tcc_motor_out

// ---- sim/tcc_amp_model.sv ----
// current-loop amplifier model holding phase commands per converter channel
`timescale 1ns/1ns
module tcc_amp_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic signed [15:0] dacA,
    input  wire logic signed [15:0] dacB,
    input  wire logic [2:0]         dacPair,
    input  wire logic               dacStrobe,
    output logic signed [15:0]      chan [0:15],
    output logic [23:0]             motorCount
);
    // =====
    // latch both phases into the selected channel pair
    always_ff @(posedge clk) begin
        if (rst) begin
            chan <= '{default: 16'h0000};
        end else if (dacStrobe) begin
            chan[{dacPair, 1'b0}] <= dacA;
            chan[{dacPair, 1'b1}] <= dacB;
        end
    end
    // shaft counts upward under positive first-phase drive
    always_ff @(posedge clk) begin
        if (rst) begin
            motorCount <= 24'h000000;
        end else if (dacStrobe && dacA > 0) begin
            motorCount <= motorCount + 24'h000001;
        end
    end
endmodule : tcc_amp_model

// ---- sim/tcc_motor_out_asserts.sv ----
// concurrent checks on the motor output stage ports
`timescale 1ns/1ns
module tcc_motor_out_asserts (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire tcc_pkg::tcc_reg_req_t  regReq,
    input wire logic [31:0]            regRdData,
    input wire logic                   servoTick,
    input wire logic signed [15:0]     servoOut,
    input wire logic signed [23:0]     motorPos,
    input wire tcc_pkg::tcc_enc_bank_t encPhase,
    input wire logic signed [15:0]     dacA,
    input wire logic signed [15:0]     dacB,
    input wire logic [2:0]             dacPair,
    input wire logic                   dacStrobe,
    input wire logic                   commActive
);
    logic [2:0] busyCnt;
    logic       enShadow;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // =====
    // count the busy cycles of an update
    always_ff @(posedge clk) begin
        if (rst) begin
            busyCnt <= 3'h0;
        end else if (servoTick && busyCnt == 3'h0) begin
            busyCnt <= 3'h6;
        end else if (busyCnt != 3'h0) begin
            busyCnt <= busyCnt - 3'h1;
        end
    end
    // mirror the written enable bit
    always_ff @(posedge clk) begin
        if (rst) begin
            enShadow <= 1'b0;
        end else if (regReq.wr && regReq.addr == tcc_pkg::REG_CTRL) begin
            enShadow <= regReq.wrData[0];
        end
    end
    chk_strobe_delay: assert property (
        servoTick && busyCnt == 3'h0 |-> ##7 dacStrobe)
        else $error("strobe missing after tick");
    chk_strobe_cause: assert property (
        dacStrobe |-> $past(servoTick, 7))
        else $error("strobe without tick");
    chk_strobe_gap: assert property (
        dacStrobe |=> !dacStrobe [*6])
        else $error("strobes too close");
    chk_out_stable: assert property (
        !dacStrobe |-> $stable(dacA) && $stable(dacB) && $stable(dacPair))
        else $error("outputs moved without strobe");
    chk_plain_zero: assert property (
        dacStrobe && !commActive |-> dacB == 16'sh0000)
        else $error("second phase driven while plain");
    chk_comm_enable: assert property (
        dacStrobe |-> commActive == enShadow)
        else $error("commutation state differs from enable");
    chk_rd_idle: assert property (
        !$past(regReq.rd) |-> regRdData == 32'h00000000)
        else $error("read data without read");
    chk_denom_readback: assert property (
        (regReq.wr && regReq.addr == tcc_pkg::REG_DENOM) ##2
        (regReq.rd && regReq.addr == tcc_pkg::REG_DENOM)
        |=> regRdData[7:0] == $past(regReq.wrData[7:0], 3))
        else $error("denominator readback wrong");
endmodule : tcc_motor_out_asserts

// ---- sim/tcc_motor_out_tb.sv ----
// self-checking bench for the motor output stage
`timescale 1ns/1ns
module tcc_motor_out_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    tcc_pkg::tcc_reg_req_t  regReq = '0;
    logic [31:0]            regRdData;
    logic                   servoTick = 1'b0;
    logic signed [15:0]     servoOut = 16'h0000;
    logic signed [23:0]     motorPos = 24'h000000;
    tcc_pkg::tcc_enc_bank_t encPhase = '0;
    logic signed [15:0]     dacA;
    logic signed [15:0]     dacB;
    logic [2:0]             dacPair;
    logic                   dacStrobe;
    logic                   commActive;
    logic signed [15:0]     chan [0:15];
    logic [23:0]            motorCount;
    int                     mismatches = 0;
    int                     testsRun = 0;
    logic [15:0] tbl [8] = '{16'h007d, 16'hffce, 16'h0053, 16'hff9f,
                             16'h003c, 16'hffd5, 16'h0081, 16'h0000};
    logic [23:0] posV [7] = '{24'h000258, 24'h000a28, 24'hfffa88,
                              24'h0000fa, 24'h000064, 24'h0007d0, 24'h00012c};
    logic [15:0] expV [7] = '{16'hd, 16'hd, 16'hd, 16'h87, 16'h3c, 16'ha, 16'h64};
    always #25 clk = ~clk;
    tcc_motor_out dut (.clk(clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
        .servoTick(servoTick), .servoOut(servoOut), .motorPos(motorPos),
        .encPhase(encPhase), .dacA(dacA), .dacB(dacB), .dacPair(dacPair),
        .dacStrobe(dacStrobe), .commActive(commActive));
    tcc_amp_model amp (.clk(clk), .rst(rst), .dacA(dacA), .dacB(dacB),
        .dacPair(dacPair), .dacStrobe(dacStrobe), .chan(chan), .motorCount(motorCount));
    // =====
    // compare, report and finish
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic complete_run();
        if (mismatches == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    // register port cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regReq.addr <= a;
        regReq.wrData <= d;
        regReq.wr <= 1'b1;
        @(posedge clk);
        regReq.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        regReq.addr <= a;
        regReq.rd <= 1'b1;
        @(posedge clk);
        regReq.rd <= 1'b0;
        #1;
        check(what, exp, regRdData);
    endtask : rd
    // one servo update, waiting a bounded time for the strobe
    task automatic tick(input logic [23:0] pos, input logic [15:0] cmd,
                        input logic [15:0] expA, input logic [15:0] expB, input string what);
        int n = 0;
        @(posedge clk);
        motorPos <= pos;
        servoOut <= cmd;
        servoTick <= 1'b1;
        @(posedge clk);
        servoTick <= 1'b0;
        #1;
        while (dacStrobe !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            complete_run();
        end
        check({what, " a"}, {16'h0000, expA}, {16'h0000, dacA});
        check({what, " b"}, {16'h0000, expB}, {16'h0000, dacB});
    endtask : tick
    // =====
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(tcc_pkg::REG_DENOM, 32'h00000001, "denom");
        rd(tcc_pkg::REG_NUMER, 32'h000003e8, "numer");
        rd(tcc_pkg::REG_ANGLE, 32'h00000055, "angle");
        rd(tcc_pkg::REG_PAIR, 32'h0000c002, "pair");
        rd(tcc_pkg::REG_FBPTR, 32'h0000c001, "fbptr");
        rd(8'h3c, 32'h00000000, "unmapped");
        tick(24'h000258, 16'h000a, 16'h000a, 16'h0000, "empty table");
        wr(tcc_pkg::REG_TDEF, 32'h080007d0);
        for (int i = 0; i < 8; i++) wr(tcc_pkg::REG_TDATA, {16'h0000, tbl[i]});
        wr(tcc_pkg::REG_TDATA, 32'h00001234);
        rd(tcc_pkg::REG_STATUS, 32'h00000001, "status");
        for (int i = 0; i < 7; i++) tick(posV[i], 16'h000a, expV[i], 16'h0000, "corr");
        check("plain", 32'h0, {31'h0, commActive});
        tick(24'h0000fa, 16'h7fff, 16'h7fff, 16'h0000, "sat hi");
        tick(24'h0001f4, 16'h8000, 16'h8000, 16'h0000, "sat lo");
        wr(tcc_pkg::REG_DENOM, 32'h00000001);
        rd(tcc_pkg::REG_DENOM, 32'h00000001, "denom wr");
        wr(tcc_pkg::REG_NUMER, 32'h00000100);
        wr(tcc_pkg::REG_ANGLE, 32'h00000040);
        wr(tcc_pkg::REG_PAIR, 32'h0000c003);
        rd(tcc_pkg::REG_PAIR, 32'h0000c002, "bad pair");
        wr(tcc_pkg::REG_PAIR, 32'h0000c03a);
        wr(tcc_pkg::REG_CTRL, 32'h00000001);
        encPhase[1] <= 24'h000040;
        tick(24'h000000, 16'h4000, 16'h0000, 16'h3fff, "angle 64");
        check("pair idx", 32'h7, {29'h0, dacPair});
        check("active", 32'h1, {31'h0, commActive});
        @(posedge clk);
        #1;
        check("chan b", 32'h3fff, {16'h0000, chan[15]});
        check("motor count", 32'h9, {8'h00, motorCount});
        wr(tcc_pkg::REG_ANGLE, 32'h000000c0);
        tick(24'h000000, 16'h4000, 16'h0000, 16'hc000, "angle 192");
        wr(tcc_pkg::REG_FBPTR, 32'h0000c005);
        tick(24'h000000, 16'h4000, 16'h3fff, 16'h0000, "enc 1");
        wr(tcc_pkg::REG_DENOM, 32'h00000003);
        wr(tcc_pkg::REG_PHREF, 32'h00000080);
        tick(24'h000000, 16'h4000, 16'h3fff, 16'h0000, "denom 3");
        wr(tcc_pkg::REG_CTRL, 32'h00000000);
        tick(24'h000000, 16'h4000, 16'h4000, 16'h0000, "off");
        complete_run();
    end
endmodule : tcc_motor_out_tb

bind tcc_motor_out tcc_motor_out_asserts chk (.clk(clk), .rst(rst), .regReq(regReq),
    .regRdData(regRdData), .servoTick(servoTick), .servoOut(servoOut), .motorPos(motorPos),
    .encPhase(encPhase), .dacA(dacA), .dacB(dacB), .dacPair(dacPair),
    .dacStrobe(dacStrobe), .commActive(commActive));
